// File: rtl/iofwd_pkg.sv
// constants for the bridge i/o forwarding decoder
package iofwd_pkg;
    // configuration byte offsets
    localparam logic [7:0] IO_BASE_LOW_OFF   = 8'h1c;
    localparam logic [7:0] IO_LIMIT_LOW_OFF  = 8'h1d;
    localparam logic [7:0] IO_BASE_HIGH_OFF  = 8'h30;
    localparam logic [7:0] IO_LIMIT_HIGH_OFF = 8'h32;
    // low nibble of the 8-bit fields: 32-bit i/o capability code
    localparam logic [3:0] IO_CAP_32BIT      = 4'h1;
    // reset values of the writable parts
    localparam logic [3:0]  IO_BASE_MID_RST   = 4'h0;
    localparam logic [15:0] IO_BASE_HIGH_RST  = 16'h0000;
    localparam logic [3:0]  IO_LIMIT_MID_RST  = 4'h0;
    localparam logic [15:0] IO_LIMIT_HIGH_RST = 16'h0000;
    // implied low address bits of base and limit
    localparam logic [11:0] IO_BASE_FILL      = 12'h000;
    localparam logic [11:0] IO_LIMIT_FILL     = 12'hfff;
    // legacy hole: offset within 1 kB block below 256 goes down
    localparam int          HOLE_BLK_HI       = 9;
    localparam int          HOLE_BLK_LO       = 8;
    localparam logic [15:0] FIRST_64K_HIGH    = 16'h0000;
    // decision codes
    typedef enum logic [1:0] {
        FWD_NONE,
        FWD_DOWN,
        FWD_UP
    } fwd_type;
endpackage : iofwd_pkg

// File: rtl/io_window_match.sv
// compares an i/o address against the assembled base/limit window
`timescale 1ns/1ps
`default_nettype none
module io_window_match (
    // window bounds
    input  wire logic [31:0] base,
    input  wire logic [31:0] limit,
    // address under test
    input  wire logic [31:0] addr,
    // results
    output logic             in_window,
    output logic             in_hole_zone,
    output logic             legacy_low
);
    // inclusive range compare; base above limit never matches
    always_comb begin
        in_window    = (addr >= base) && (addr <= limit);
        in_hole_zone = in_window && (addr[31:16] == iofwd_pkg::FIRST_64K_HIGH);
        legacy_low   = (addr[iofwd_pkg::HOLE_BLK_HI:iofwd_pkg::HOLE_BLK_LO] == 2'b00);
    end
endmodule : io_window_match
`default_nettype wire

// File: rtl/bridge_io_forward_decode.sv
// forwarding decision for i/o and memory transactions of a pci-pci bridge
`timescale 1ns/1ps
`default_nettype none
module bridge_io_forward_decode (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    // configuration write port, byte wide
    input  wire logic        CFG_WR,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [7:0]  CFG_WDATA,
    // configuration read port, byte wide, registered data
    input  wire logic        CFG_RD,
    output logic [7:0]       CFG_RDATA,
    // command and control bits
    input  wire logic        IO_DECODE_EN,
    input  wire logic        MEM_DECODE_EN,
    input  wire logic        UPSTREAM_EN,
    input  wire logic        LEGACY_BUS_HOLE_MODE,
    // primary bus request
    input  wire logic        PRI_REQ,
    input  wire logic        PRI_IS_IO,
    input  wire logic [31:0] PRI_ADDR,
    input  wire logic        PRI_MEM_HIT,
    // secondary bus request
    input  wire logic        SEC_REQ,
    input  wire logic        SEC_IS_IO,
    input  wire logic [31:0] SEC_ADDR,
    input  wire logic        SEC_MEM_HIT,
    // decisions
    output logic             PRI_FWD_DOWN,
    output logic             SEC_FWD_UP,
    output logic [31:0]      DOWN_ADDR,
    output logic [31:0]      UP_ADDR
);
    // overview of the decoder
    // one pci clock domain; every input but NRST is taken as synchronous
    // the decision for a request is registered, so a claim shows
    // on the clock after the address cycle and stands one cycle
    // primary and secondary requests are judged independently,
    // so both buses may present an address in the same cycle
    // memory window hits are decoded outside and arrive as flags;
    // only their enable gating and the upstream default live here
    // no address translation: forwarded addresses are copied as is

    // reset release: the pin reset clears at once, but release is
    // passed through two flip-flops so every register leaves reset
    // on the same clock edge; only the second stage is used below
    // reset synchroniser
    logic rst_meta_reg;       // first stage
    logic rst_sync_n_reg;     // released reset

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rst_meta_reg   <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // window bounds are kept only as their writable bits;
    // the low twelve address bits are implied by the decode
    // granularity (zeros for base, ones for limit), so the
    // window can never be narrower than 4 kB nor misaligned
    // the low nibble of each 8-bit field is not stored at all;
    // it is a constant capability code supplied on reads
    // window register state
    logic [3:0]  base_mid_reg,   base_mid_next;    // base bits 15:12
    logic [15:0] base_high_reg,  base_high_next;   // base bits 31:16
    logic [3:0]  limit_mid_reg,  limit_mid_next;   // limit bits 15:12
    logic [15:0] limit_high_reg, limit_high_next;  // limit bits 31:16
    logic [7:0]  rdata_reg,      rdata_next;       // read data

    // bounds are rebuilt combinationally from the stored fields;
    // the full 32-bit compare lets the window sit anywhere in
    // the 4 GB port space, above or below the 64 kB line
    // assembled 32-bit bounds with 4 kB granularity
    logic [31:0] io_base;
    logic [31:0] io_limit;
    assign io_base  = {base_high_reg, base_mid_reg, iofwd_pkg::IO_BASE_FILL};
    assign io_limit = {limit_high_reg, limit_mid_reg, iofwd_pkg::IO_LIMIT_FILL};

    // configuration port behaviour
    // - one byte per strobe; the 16-bit upper halves are written
    //   as two bytes, low byte at the even offset
    // - a write to an offset not held here is dropped silently
    // - a read of an unmapped offset returns zero
    // - a read in the same cycle as a write returns the old value,
    //   because read data is taken from the registers, not the bus
    // - read data is registered and holds until the next read
    // hazard: software must not move the window while either bus
    // has a transfer in flight; a half-written 16-bit upper field
    // gives a transient window between the two byte writes
    // register writes and reads
    always_comb begin
        base_mid_next   = base_mid_reg;
        base_high_next  = base_high_reg;
        limit_mid_next  = limit_mid_reg;
        limit_high_next = limit_high_reg;
        rdata_next      = rdata_reg;
        if (CFG_WR) begin
            unique case (CFG_ADDR)
                // only the upper nibble is writable
                iofwd_pkg::IO_BASE_LOW_OFF:       base_mid_next = CFG_WDATA[7:4];
                iofwd_pkg::IO_LIMIT_LOW_OFF:      limit_mid_next = CFG_WDATA[7:4];
                iofwd_pkg::IO_BASE_HIGH_OFF:      base_high_next[7:0] = CFG_WDATA;
                iofwd_pkg::IO_BASE_HIGH_OFF + 8'h01:  base_high_next[15:8] = CFG_WDATA;
                iofwd_pkg::IO_LIMIT_HIGH_OFF:     limit_high_next[7:0] = CFG_WDATA;
                iofwd_pkg::IO_LIMIT_HIGH_OFF + 8'h01: limit_high_next[15:8] = CFG_WDATA;
                default: ;                        // other offsets not held here
            endcase
        end
        if (CFG_RD) begin
            unique case (CFG_ADDR)
                iofwd_pkg::IO_BASE_LOW_OFF:       rdata_next = {base_mid_reg, iofwd_pkg::IO_CAP_32BIT};
                iofwd_pkg::IO_LIMIT_LOW_OFF:      rdata_next = {limit_mid_reg, iofwd_pkg::IO_CAP_32BIT};
                iofwd_pkg::IO_BASE_HIGH_OFF:      rdata_next = base_high_reg[7:0];
                iofwd_pkg::IO_BASE_HIGH_OFF + 8'h01:  rdata_next = base_high_reg[15:8];
                iofwd_pkg::IO_LIMIT_HIGH_OFF:     rdata_next = limit_high_reg[7:0];
                iofwd_pkg::IO_LIMIT_HIGH_OFF + 8'h01: rdata_next = limit_high_reg[15:8];
                default:                          rdata_next = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // reset leaves base 0000_0000 and limit 0000_0fff, a window
    // over the bottom 4 kB; the enables are held outside this
    // block and are expected to be off until software has
    // programmed the window
    // register state, reset to the bottom 4 kB window
    always_ff @(posedge CLK_SYS or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            base_mid_reg   <= iofwd_pkg::IO_BASE_MID_RST;
            base_high_reg  <= iofwd_pkg::IO_BASE_HIGH_RST;
            limit_mid_reg  <= iofwd_pkg::IO_LIMIT_MID_RST;
            limit_high_reg <= iofwd_pkg::IO_LIMIT_HIGH_RST;
            rdata_reg      <= 8'h00;
        end else begin
            base_mid_reg   <= base_mid_next;
            base_high_reg  <= base_high_next;
            limit_mid_reg  <= limit_mid_next;
            limit_high_reg <= limit_high_next;
            rdata_reg      <= rdata_next;
        end
    end
    assign CFG_RDATA = rdata_reg;

    // one comparator per bus, both fed from the same bounds, so a
    // change of window takes effect on both sides together
    // the comparator also flags the legacy hole zone (inside the
    // window and below 64 kB) and the low quarter of a 1 kB block
    // base above limit gives no match at all, which turns the
    // window off without a separate disable bit
    // window matching for each bus
    logic pri_in_win;   // primary address in window
    logic pri_hole;     // primary in window below 64 kB
    logic pri_low;      // primary in low 256 of a 1 kB block
    logic sec_in_win;   // secondary address in window
    logic sec_hole;     // secondary in window below 64 kB
    logic sec_low;      // secondary in low 256 of a 1 kB block

    io_window_match u_pri_match (
        .base         (io_base),
        .limit        (io_limit),
        .addr         (PRI_ADDR),
        .in_window    (pri_in_win),
        .in_hole_zone (pri_hole),
        .legacy_low   (pri_low)
    );

    io_window_match u_sec_match (
        .base         (io_base),
        .limit        (io_limit),
        .addr         (SEC_ADDR),
        .in_window    (sec_in_win),
        .in_hole_zone (sec_hole),
        .legacy_low   (sec_low)
    );

    // decisions are kept as an enum so that the gating of each
    // branch reads clearly; only claim or no claim reaches the
    // registers on each side
    // decision state
    iofwd_pkg::fwd_type pri_dec, sec_dec;  // combinational decisions
    logic        down_reg, down_next;      // registered downstream claim
    logic        up_reg,   up_next;        // registered upstream claim
    logic [31:0] daddr_reg, daddr_next;    // forwarded primary address
    logic [31:0] uaddr_reg, uaddr_next;    // forwarded secondary address

    // primary decision order
    // - no request: no claim
    // - i/o with port decode off: ignored outright
    // - i/o in the hole zone with hole mode on: only the low
    //   256 bytes of each 1 kB block are claimed
    // - other i/o: claimed when inside the window
    // - memory: claimed on a window hit with memory decode on
    // the hole test comes before the plain window test because the
    // hole zone is a subset of the window
    // primary side: claim for downstream forwarding
    always_comb begin
        pri_dec = iofwd_pkg::FWD_NONE;
        if (PRI_REQ) begin
            if (PRI_IS_IO) begin
                if (!IO_DECODE_EN) begin
                    pri_dec = iofwd_pkg::FWD_NONE;
                end else if (LEGACY_BUS_HOLE_MODE && pri_hole) begin
                    // hole mode: only the low quarter of each 1 kB block
                    if (pri_low) begin
                        pri_dec = iofwd_pkg::FWD_DOWN;
                    end
                end else if (pri_in_win) begin
                    pri_dec = iofwd_pkg::FWD_DOWN;
                end
            end else if (MEM_DECODE_EN && PRI_MEM_HIT) begin
                pri_dec = iofwd_pkg::FWD_DOWN;
            end
        end
    end

    // secondary decision order
    // - upstream enable off: nothing is forwarded, i/o or memory
    // - i/o in the hole zone with hole mode on: the upper 768
    //   bytes of each 1 kB block go up, the low 256 stay below
    // - other i/o: forwarded up only when outside the window,
    //   which covers out-of-window addresses below 64 kB as well
    // - memory: forwarded up whenever no downstream window hits
    // the two sides are exact complements for i/o while both
    // enables are on, so the address space has no gaps
    // secondary side: everything not claimed downstream goes up
    always_comb begin
        sec_dec = iofwd_pkg::FWD_NONE;
        if (SEC_REQ && UPSTREAM_EN) begin
            if (SEC_IS_IO) begin
                if (LEGACY_BUS_HOLE_MODE && sec_hole) begin
                    if (!sec_low) begin
                        sec_dec = iofwd_pkg::FWD_UP;
                    end
                end else if (!sec_in_win) begin
                    sec_dec = iofwd_pkg::FWD_UP;
                end
            end else if (!SEC_MEM_HIT) begin
                sec_dec = iofwd_pkg::FWD_UP;
            end
        end
    end

    // the address registers load only on a claim, so an address
    // cycle that is not forwarded leaves the last claim visible
    // unchanged for whoever is still consuming it
    // next values of the decision outputs
    always_comb begin
        down_next  = (pri_dec == iofwd_pkg::FWD_DOWN);
        up_next    = (sec_dec == iofwd_pkg::FWD_UP);
        daddr_next = down_next ? PRI_ADDR : daddr_reg;
        uaddr_next = up_next ? SEC_ADDR : uaddr_reg;
    end

    // claim flags are pulses: high for one cycle per qualifying
    // request cycle; the forwarded addresses hold the last claim
    // so a consumer may sample them any time after the flag
    // decision registers
    always_ff @(posedge CLK_SYS or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            down_reg  <= 1'b0;
            up_reg    <= 1'b0;
            daddr_reg <= 32'h0000_0000;
            uaddr_reg <= 32'h0000_0000;
        end else begin
            down_reg  <= down_next;
            up_reg    <= up_next;
            daddr_reg <= daddr_next;
            uaddr_reg <= uaddr_next;
        end
    end

    assign PRI_FWD_DOWN = down_reg;
    assign SEC_FWD_UP   = up_reg;
    assign DOWN_ADDR    = daddr_reg;
    assign UP_ADDR      = uaddr_reg;
endmodule : bridge_io_forward_decode
`default_nettype wire

// File: testbench/iofwd_initiators.sv
// initiator model for the primary and secondary buses
`timescale 1ns/1ps
`default_nettype none
module iofwd_initiators (
    // clock
    input  wire logic        clk,
    // primary bus request
    output logic             pri_req,
    output logic             pri_is_io,
    output logic [31:0]      pri_addr,
    output logic             pri_mem_hit,
    // secondary bus request
    output logic             sec_req,
    output logic             sec_is_io,
    output logic [31:0]      sec_addr,
    output logic             sec_mem_hit
);
    // both buses idle at time zero
    initial {pri_req, pri_is_io, pri_addr, pri_mem_hit} = '0;
    initial {sec_req, sec_is_io, sec_addr, sec_mem_hit} = '0;
    // one address cycle; released lines flip so stale values never match
    task automatic issue(input logic s, io, input logic [31:0] a, input logic hit);
        @(negedge clk);
        if (s) {sec_req, sec_is_io, sec_addr, sec_mem_hit} = {1'b1, io, a, hit};
        else {pri_req, pri_is_io, pri_addr, pri_mem_hit} = {1'b1, io, a, hit};
        @(negedge clk);
        pri_req = 1'b0;
        sec_req = 1'b0;
        pri_addr = ~pri_addr;
        sec_addr = ~sec_addr;
    endtask : issue
endmodule : iofwd_initiators
`default_nettype wire

// File: testbench/bridge_io_forward_decode_assertions.sv
// concurrent checks on the forwarding decoder ports
`timescale 1ns/1ps
`default_nettype none
module bridge_io_forward_decode_assertions (
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    input wire logic        CFG_RD,
    input wire logic [7:0]  CFG_ADDR,
    input wire logic [7:0]  CFG_RDATA,
    input wire logic        IO_DECODE_EN,
    input wire logic        MEM_DECODE_EN,
    input wire logic        UPSTREAM_EN,
    input wire logic        LEGACY_BUS_HOLE_MODE,
    input wire logic        PRI_REQ,
    input wire logic        PRI_IS_IO,
    input wire logic [31:0] PRI_ADDR,
    input wire logic        PRI_MEM_HIT,
    input wire logic        SEC_REQ,
    input wire logic        SEC_IS_IO,
    input wire logic [31:0] SEC_ADDR,
    input wire logic        SEC_MEM_HIT,
    input wire logic        PRI_FWD_DOWN,
    input wire logic        SEC_FWD_UP,
    input wire logic [31:0] DOWN_ADDR,
    input wire logic [31:0] UP_ADDR
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // i/o address cycles on each bus
    sequence pri_io_s; PRI_REQ && PRI_IS_IO; endsequence
    sequence sec_io_s; SEC_REQ && SEC_IS_IO; endsequence
    // upper 768 bytes of a 1 kB block below 64 kB
    sequence pri_hole_s; pri_io_s ##0 (LEGACY_BUS_HOLE_MODE && PRI_ADDR[31:16] == 16'h0000
        && PRI_ADDR[9:8] != 2'h0); endsequence
    sequence sec_hole_s; sec_io_s ##0 (LEGACY_BUS_HOLE_MODE && SEC_ADDR[31:16] == 16'h0000
        && SEC_ADDR[9:8] != 2'h0 && UPSTREAM_EN); endsequence
    a_io_gate_off: assert property (pri_io_s ##0 !IO_DECODE_EN |=> !PRI_FWD_DOWN)
        else $error("primary i/o claimed with decode off");
    a_up_gate_off: assert property (SEC_REQ && !UPSTREAM_EN |=> !SEC_FWD_UP)
        else $error("secondary claimed with upstream off");
    a_mem_down_on: assert property (PRI_REQ && !PRI_IS_IO && MEM_DECODE_EN && PRI_MEM_HIT
        |=> PRI_FWD_DOWN) else $error("memory hit not forwarded down");
    a_mem_down_off: assert property (PRI_REQ && !PRI_IS_IO && !MEM_DECODE_EN
        |=> !PRI_FWD_DOWN) else $error("memory forwarded with decode off");
    a_mem_up_miss: assert property (SEC_REQ && !SEC_IS_IO && UPSTREAM_EN
        |=> SEC_FWD_UP == !$past(SEC_MEM_HIT)) else $error("memory upstream decision wrong");
    a_hole_no_down: assert property (pri_hole_s |=> !PRI_FWD_DOWN)
        else $error("hole address forwarded down");
    a_hole_goes_up: assert property (sec_hole_s |=> SEC_FWD_UP)
        else $error("hole address not forwarded up");
    a_down_addr_same: assert property (PRI_FWD_DOWN |-> DOWN_ADDR == $past(PRI_ADDR))
        else $error("downstream address altered");
    a_up_addr_same: assert property (SEC_FWD_UP |-> UP_ADDR == $past(SEC_ADDR))
        else $error("upstream address altered");
    a_cap_nibble: assert property (CFG_RD && (CFG_ADDR == 8'h1c || CFG_ADDR == 8'h1d)
        |=> CFG_RDATA[3:0] == 4'h1) else $error("capability nibble wrong");
endmodule : bridge_io_forward_decode_assertions
bind bridge_io_forward_decode bridge_io_forward_decode_assertions chk_u (
    .CLK_SYS              (CLK_SYS),
    .NRST                 (NRST),
    .CFG_RD               (CFG_RD),
    .CFG_ADDR             (CFG_ADDR),
    .CFG_RDATA            (CFG_RDATA),
    .IO_DECODE_EN         (IO_DECODE_EN),
    .MEM_DECODE_EN        (MEM_DECODE_EN),
    .UPSTREAM_EN          (UPSTREAM_EN),
    .LEGACY_BUS_HOLE_MODE (LEGACY_BUS_HOLE_MODE),
    .PRI_REQ              (PRI_REQ),
    .PRI_IS_IO            (PRI_IS_IO),
    .PRI_ADDR             (PRI_ADDR),
    .PRI_MEM_HIT          (PRI_MEM_HIT),
    .SEC_REQ              (SEC_REQ),
    .SEC_IS_IO            (SEC_IS_IO),
    .SEC_ADDR             (SEC_ADDR),
    .SEC_MEM_HIT          (SEC_MEM_HIT),
    .PRI_FWD_DOWN         (PRI_FWD_DOWN),
    .SEC_FWD_UP           (SEC_FWD_UP),
    .DOWN_ADDR            (DOWN_ADDR),
    .UP_ADDR              (UP_ADDR)
);
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the i/o forwarding decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic cfg_wr = 1'b0, cfg_rd = 1'b0, io_en = 1'b0, mem_en = 1'b0, up_en = 1'b0, hole = 1'b0;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
    wire logic pri_req, pri_is_io, pri_mem_hit, sec_req, sec_is_io, sec_mem_hit, f_dn, f_up;
    wire logic [31:0] pri_addr, sec_addr, down_addr, up_addr;
    wire logic [7:0] cfg_rdata;
    int fails = 0, checks = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    iofwd_initiators ini_u (.clk(clk_sys), .pri_req, .pri_is_io, .pri_addr, .pri_mem_hit,
        .sec_req, .sec_is_io, .sec_addr, .sec_mem_hit);
    bridge_io_forward_decode dut_u (.CLK_SYS(clk_sys), .NRST(nrst), .CFG_WR(cfg_wr),
        .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .CFG_RD(cfg_rd), .CFG_RDATA(cfg_rdata),
        .IO_DECODE_EN(io_en), .MEM_DECODE_EN(mem_en), .UPSTREAM_EN(up_en),
        .LEGACY_BUS_HOLE_MODE(hole), .PRI_REQ(pri_req), .PRI_IS_IO(pri_is_io),
        .PRI_ADDR(pri_addr), .PRI_MEM_HIT(pri_mem_hit), .SEC_REQ(sec_req), .SEC_IS_IO(sec_is_io),
        .SEC_ADDR(sec_addr), .SEC_MEM_HIT(sec_mem_hit), .PRI_FWD_DOWN(f_dn), .SEC_FWD_UP(f_up),
        .DOWN_ADDR(down_addr), .UP_ADDR(up_addr));
    // one config byte write
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk_sys);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge clk_sys);
        cfg_wr = 1'b0;
    endtask : wr
    // one config byte read, data judged the cycle after
    task automatic rd(input logic [7:0] a, ex);
        @(negedge clk_sys);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge clk_sys);
        cfg_rd = 1'b0;
        `CHK("cfg_rdata", ex, cfg_rdata)
    endtask : rd
    // whole base and limit, bytewise
    task automatic win(input logic [31:0] b, l);
        {io_en, up_en} = 2'b00;
        wr(8'h1c, {b[15:12], 4'h0});
        wr(8'h30, b[23:16]);
        wr(8'h31, b[31:24]);
        wr(8'h1d, {l[15:12], 4'h0});
        wr(8'h32, l[23:16]);
        wr(8'h33, l[31:24]);
        {io_en, up_en} = 2'b11;
    endtask : win
    // one transfer and its forwarding decision
    task automatic go(input logic s, io, input logic [31:0] a, input logic hit, ex);
        ini_u.issue(s, io, a, hit);
        if (s) begin
            `CHK("sec_fwd_up", ex, f_up)
            if (ex) `CHK("up_addr", a, up_addr)
        end else begin
            `CHK("pri_fwd_down", ex, f_dn)
            if (ex) `CHK("down_addr", a, down_addr)
        end
    endtask : go
    // reset values and the bottom 4 kB window
    task automatic t_reset;
        rd(8'h1c, 8'h01);
        rd(8'h1d, 8'h01);
        rd(8'h31, 8'h00);
        rd(8'h33, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        {io_en, up_en} = 2'b11;
        go(1'b0, 1'b1, 32'h00000fff, 1'b0, 1'b1);
        go(1'b0, 1'b1, 32'h00001000, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h00001000, 1'b0, 1'b1);
        go(1'b1, 1'b1, 32'h00000000, 1'b0, 1'b0);
    endtask : t_reset
    // 32-bit window edges and enable gating
    task automatic t_window;
        win(32'h00012000, 32'h00034fff);
        rd(8'h30, 8'h01);
        rd(8'h32, 8'h03);
        wr(8'h1c, 8'h2f);
        rd(8'h1c, 8'h21);
        go(1'b0, 1'b1, 32'h00011fff, 1'b0, 1'b0);
        go(1'b0, 1'b1, 32'h00012000, 1'b0, 1'b1);
        go(1'b0, 1'b1, 32'h00034fff, 1'b0, 1'b1);
        go(1'b0, 1'b1, 32'h00035000, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h00035000, 1'b0, 1'b1);
        go(1'b1, 1'b1, 32'h00012000, 1'b0, 1'b0);
        {io_en, up_en} = 2'b00;
        go(1'b0, 1'b1, 32'h00012000, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h00035000, 1'b0, 1'b0);
        go(1'b1, 1'b0, 32'h00035000, 1'b0, 1'b0);
    endtask : t_window
    // base above limit turns the window off
    task automatic t_off;
        win(32'h00035000, 32'h00034fff);
        go(1'b0, 1'b1, 32'h00034fff, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h00034fff, 1'b0, 1'b1);
        go(1'b1, 1'b1, 32'h00035000, 1'b0, 1'b1);
    endtask : t_off
    // legacy hole below 64 kB, plain decode above
    task automatic t_hole;
        win(32'h00000000, 32'h0001ffff);
        hole = 1'b1;
        go(1'b0, 1'b1, 32'h000004ff, 1'b0, 1'b1);
        go(1'b0, 1'b1, 32'h00000500, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h00000b00, 1'b0, 1'b1);
        go(1'b0, 1'b1, 32'h00010500, 1'b0, 1'b1);
        go(1'b1, 1'b1, 32'h00010500, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h000000ff, 1'b0, 1'b0);
        go(1'b1, 1'b1, 32'h00020000, 1'b0, 1'b1);
        hole = 1'b0;
    endtask : t_hole
    // memory enable gating
    task automatic t_mem;
        go(1'b0, 1'b0, 32'h00000123, 1'b1, 1'b0);
        mem_en = 1'b1;
        go(1'b0, 1'b0, 32'h00000123, 1'b1, 1'b1);
        go(1'b0, 1'b0, 32'h00000456, 1'b0, 1'b0);
        go(1'b1, 1'b0, 32'h00000789, 1'b1, 1'b0);
        go(1'b1, 1'b0, 32'h00000789, 1'b0, 1'b1);
    endtask : t_mem
    // counts and verdict
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_window();
        t_off();
        t_hole();
        t_mem();
        summarize();
    end
endmodule : testbench
`default_nettype wire
